// [design/dpim_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - twenty-three sources, numbered zero to twenty-two, each owning one event bit
// R2 - system request is power-down OR system pin, synced rising, then falling edge
// R3 - system request treated like any other source, no hardware priority
// R4 - enable masking covers every source including the system request
// R5 - internal sources are active-high level requests
// R6 - modem pin is an active-low level request
// R7 - print, two external and system pins: programmable polarity and edge/level
// R8 - every external pin passes a synchroniser before use
// R9 - no ranking and no vectors, only masking and request lines
// R10 - set enable lets its event request, cleared enable blocks it
// R11 - event bit sets on rising edge when source active, regardless of enable
// R12 - normal and fast request outputs update on the falling clock edge
// R13 - two independent enable sets, one per request output
// R14 - event bit clears on the rising edge after its source withdraws
// R15 - software bit is its own source, holds the value firmware writes
// R16 - sources latch requests until serviced; firmware clears the source
// R17 - enabling an already pending event raises the request at once
// R18 - firmware keeps external enables zero while shared pins serve as GPIO
// R19 - shared pin direction must stay input while a source drives it
// R20 - a write to the lockout enable register also raises a reset
// R21 - events 0-15 in first event register, 16-22 in second, read-only but software
// R22 - request asserted while any event meets its path enable, else released
module dpim_ctrl
   import dpim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [22:0] internal_req,
   input wire logic power_down_req,
   input wire logic modem_request_n,
   input wire logic print_subsystem_request_n,
   input wire logic ext_request_one_pin,
   input wire logic ext_request_two_pin,
   input wire logic system_request_pin,
   output logic normal_request_out_n,
   output logic fast_request_out_n,
   output logic lockout_reset
);
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic sys_neg_r;
   logic [NUM_PROG-1:0] prev_r;
   logic [NUM_PROG-1:0] edge_hit_r;
   logic [NUM_SRC-1:0] evt_r;
   logic [NUM_SRC-1:0] nen_r;
   logic [NUM_SRC-1:0] fen_r;
   logic [7:0] pcfg_r;
   logic sw_r;
   logic [31:0] rd_r;
   logic wait_r;
   logic lock_r;
   logic norm_r;
   logic fast_r;

   wire logic [4:0] pins = {system_request_pin, ext_request_two_pin, ext_request_one_pin,
                            print_subsystem_request_n, modem_request_n};
   wire logic req = avs_read | avs_write;
   wire logic acc = req & ~wait_r;
   wire logic wr_acc = acc & avs_write;
   wire logic be_lo = avs_byteenable[0];
   wire logic be_hi = avs_byteenable[1];
   wire logic [15:0] wd = avs_writedata[15:0];
   wire logic [NUM_PROG-1:0] prog_act;
   wire logic [NUM_PROG-1:0] prog_lvl;
   wire logic [NUM_PROG-1:0] prog_src;
   wire logic [NUM_PROG-1:0] edge_clr = (wr_acc && be_lo && avs_address == ECLR_IDX) ?
                                        wd[NUM_PROG-1:0] : 4'h0;
   logic [NUM_SRC-1:0] prog_vec;
   wire logic modem_src = ~sync2_r[0] | internal_req[SRC_MODEM]; // R6
   wire logic [NUM_SRC-1:0] src = (internal_req & INT_SRC_MASK) // R5 R1
                                  | prog_vec
                                  | ({{(NUM_SRC-1){1'b0}}, modem_src} << SRC_MODEM)
                                  | ({{(NUM_SRC-1){1'b0}}, sw_r} << SRC_SW); // R15
   wire logic norm_nxt = ~|(evt_r & nen_r); // R22 R10 R4 R9
   wire logic fast_nxt = ~|(evt_r & fen_r); // R13 R22
   wire logic [31:0] rd_mux =
      (avs_address == EVT1_IDX) ? {16'h0000, evt_r[15:0]} : // R21
      (avs_address == EVT2_IDX) ? {25'h0000000, evt_r[22:16]} : // R21
      (avs_address == NEN1_IDX) ? {16'h0000, nen_r[15:0]} :
      (avs_address == NEN2_IDX) ? {25'h0000000, nen_r[22:16]} :
      (avs_address == FEN1_IDX) ? {16'h0000, fen_r[15:0]} :
      (avs_address == FEN2_IDX) ? {25'h0000000, fen_r[22:16]} :
      (avs_address == PCFG_IDX) ? {24'h000000, pcfg_r} :
      (avs_address == ECLR_IDX) ? {28'h0000000, edge_hit_r} : RD_ZERO;

   // pins never reach logic before the second flop
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end else begin
         sync1_r <= pins; // R8
         sync2_r <= sync1_r; // R8
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PROG; gi = gi + 1) begin : g_prog
         assign prog_act[gi] = pcfg_r[2*gi+PCFG_POL] ? sync2_r[gi+1] : ~sync2_r[gi+1]; // R7
         if (gi == PROG_SYS) begin : g_sys
            assign prog_lvl[gi] = sys_neg_r; // R2
         end else begin : g_pin
            assign prog_lvl[gi] = prog_act[gi];
         end
         assign prog_src[gi] = pcfg_r[2*gi+PCFG_EDGE] ? edge_hit_r[gi] : prog_lvl[gi]; // R7
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               prev_r[gi] <= 1'b0;
               edge_hit_r[gi] <= 1'b0;
            end else begin
               prev_r[gi] <= prog_lvl[gi];
               // a new edge wins over a clear in the same cycle
               if (prog_lvl[gi] & ~prev_r[gi]) begin
                  edge_hit_r[gi] <= 1'b1; // R7
               end else if (edge_clr[gi]) begin
                  edge_hit_r[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_comb begin
      prog_vec = {NUM_SRC{1'b0}};
      for (int i = 0; i < NUM_PROG; i++) begin
         prog_vec[PROG_POS[i]] = prog_src[i];
      end
   end

   // second stage of the system request path lives on the falling edge
   always_ff @(negedge sys_clk) begin
      if (sys_rst) begin
         sys_neg_r <= 1'b0;
      end else begin
         sys_neg_r <= prog_act[PROG_SYS] | power_down_req; // R2 R3
      end
   end

   // events follow their source; clearing is done at the source
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         evt_r <= EVT_RST;
      end else begin
         evt_r <= src; // R11 R14 R16
      end
   end

   always_ff @(negedge sys_clk) begin
      if (sys_rst) begin
         norm_r <= 1'b1;
         fast_r <= 1'b1;
      end else begin
         norm_r <= norm_nxt; // R12 R17
         fast_r <= fast_nxt; // R12 R13
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         nen_r <= EN_RST;
         fen_r <= EN_RST;
         pcfg_r <= PCFG_RST;
         sw_r <= 1'b0;
      end else if (wr_acc) begin
         if (be_lo && avs_address == EVT2_IDX) begin
            sw_r <= wd[SW_BIT]; // R15
         end
         if (be_lo && avs_address == NEN1_IDX) begin
            nen_r[7:0] <= wd[7:0]; // R10
         end
         if (be_hi && avs_address == NEN1_IDX) begin
            nen_r[15:8] <= wd[15:8];
         end
         if (be_lo && avs_address == NEN2_IDX) begin
            nen_r[22:16] <= wd[6:0];
         end
         if (be_lo && avs_address == FEN1_IDX) begin
            fen_r[7:0] <= wd[7:0]; // R13
         end
         if (be_hi && avs_address == FEN1_IDX) begin
            fen_r[15:8] <= wd[15:8];
         end
         if (be_lo && avs_address == FEN2_IDX) begin
            fen_r[22:16] <= wd[6:0];
         end
         if (be_lo && avs_address == PCFG_IDX) begin
            pcfg_r <= wd[7:0];
         end
      end
   end

   // one wait cycle per access keeps readdata a plain registered mux
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wait_r <= 1'b1;
         rd_r <= RD_ZERO;
         lock_r <= 1'b0;
      end else begin
         wait_r <= ~(req & wait_r);
         if (req & wait_r) begin
            rd_r <= rd_mux;
         end
         lock_r <= wr_acc && avs_address == LOCK_IDX; // R20
      end
   end

   assign avs_readdata = rd_r;
   assign avs_waitrequest = wait_r;
   assign lockout_reset = lock_r;
   assign normal_request_out_n = norm_r;
   assign fast_request_out_n = fast_r;

   // watched on the source that the bench really raises, so the check is not vacuous
   sequence s_en_rise;
      evt_r[1] && !nen_r[1] ##1 evt_r[1] && nen_r[1];
   endsequence
   sequence s_sw_set;
      wr_acc && be_lo && avs_address == EVT2_IDX && avs_writedata[SW_BIT];
   endsequence

   a_modem_low_level: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6 R8
      (!modem_request_n)[*3] |=> evt_r[SRC_MODEM]) else $error("modem event missing");
   a_internal_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14 R5
      $fell(internal_req[1]) |=> !evt_r[1]) else $error("event did not clear");
   a_normal_mask: assert property (@(negedge sys_clk) disable iff (sys_rst) // R22 R10
      1'b1 |=> normal_request_out_n == !$past(|(evt_r & nen_r))) else $error("normal out wrong");
   a_fast_mask: assert property (@(negedge sys_clk) disable iff (sys_rst) // R13
      1'b1 |=> fast_request_out_n == !$past(|(evt_r & fen_r))) else $error("fast out wrong");
   a_pending_enable: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
      s_en_rise |=> !normal_request_out_n) else $error("pending event not raised");
   a_sw_source: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
      s_sw_set |-> ##2 evt_r[SRC_SW]) else $error("software event not set");
   a_lockout_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst) // R20
      wr_acc && avs_address == LOCK_IDX |=> lockout_reset ##1 !lockout_reset)
      else $error("lockout reset pulse wrong");
   a_sys_path: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2 R3
      (power_down_req && !pcfg_r[2*PROG_SYS+PCFG_EDGE])[*2] |=> evt_r[SRC_SYS])
      else $error("system event missing");
   a_bus_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
      req && avs_waitrequest |-> ##1 !avs_waitrequest) else $error("slave did not answer");
   a_edge_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
      edge_hit_r[0] && !edge_clr[0] |=> edge_hit_r[0]) else $error("edge latch lost");
   a_event_unmasked: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
      internal_req[1] |=> evt_r[1]) else $error("event needs no enable");
   a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (sys_rst) // R21
      req && wait_r && avs_address > LOCK_IDX |=> avs_readdata == RD_ZERO)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// [design/dpim_pkg.sv]
package dpim_pkg;
   localparam int NUM_SRC = 23;
   localparam int NUM_PROG = 4;
   localparam int NUM_PIN = 5;
   // word indices on the slave port; byte address is four times the index
   localparam logic [7:0] EVT1_IDX = 8'h20;
   localparam logic [7:0] EVT2_IDX = 8'h22;
   localparam logic [7:0] NEN1_IDX = 8'h24;
   localparam logic [7:0] NEN2_IDX = 8'h26;
   localparam logic [7:0] FEN1_IDX = 8'h28;
   localparam logic [7:0] FEN2_IDX = 8'h2a;
   localparam logic [7:0] PCFG_IDX = 8'h2c;
   localparam logic [7:0] ECLR_IDX = 8'h2e;
   localparam logic [7:0] LOCK_IDX = 8'h30;
   localparam int SRC_MODEM = 0;
   localparam int SRC_SYS = 16;
   localparam int SRC_SW = 17;
   localparam int SW_BIT = 1;
   localparam int PROG_POS [0:3] = '{2, 11, 13, 16};
   localparam int PCFG_POL = 0;
   localparam int PCFG_EDGE = 1;
   localparam int PROG_SYS = 3;
   localparam logic [22:0] INT_SRC_MASK = 23'h7cd7fb;
   localparam logic [22:0] EVT_RST = 23'h000000;
   localparam logic [22:0] EN_RST = 23'h000000;
   localparam logic [7:0] PCFG_RST = 8'h00;
   localparam logic [4:0] SYNC_RST = 5'h1f;
   localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage

// [test/dpim_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dpim_src_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic fire,
   input wire logic service,
   output logic held_r
);
   // a one-cycle trigger is stretched into a level until serviced
   always_ff @(posedge sys_clk) begin
      if (sys_rst || service) begin
         held_r <= 1'b0;
      end else if (fire) begin
         held_r <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [test/test_dual_path_irq_masking_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_path_irq_masking_controller;
   import dpim_pkg::*;
   logic sys_clk, sys_rst, avs_read, avs_write, fire, service, held;
   logic avs_waitrequest, nrq_n, frq_n, lk, pd, modem_n, prt_n, sys_pin, ext1, ext2;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [22:0] ireq;
   int err_count, comparisons, pulses;
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
   dpim_ctrl u_dpim_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .internal_req(ireq | {21'h0, held, 1'b0}), .power_down_req(pd),
      .modem_request_n(modem_n), .print_subsystem_request_n(prt_n),
      .ext_request_one_pin(ext1), .ext_request_two_pin(ext2),
      .system_request_pin(sys_pin), .normal_request_out_n(nrq_n),
      .fast_request_out_n(frq_n), .lockout_reset(lk));
   dpim_src_model u_dpim_src_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .fire(fire), .service(service), .held_r(held));
   task wrap_up();
      if (err_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one edge after release keeps back-to-back strobes from colliding
   task wr(input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task chk_rd(input logic [7:0] a, input logic [31:0] e, input string n);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      `CHK(n, e, avs_readdata)
      @(posedge sys_clk);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (lk === 1'b1) pulses <= pulses + 1;
   initial begin
      #20us;
      err_count++;
      wrap_up();
   end
   initial begin
      sys_rst = 1'b1;
      {avs_read, avs_write, fire, service, pd} = 5'h00;
      {modem_n, prt_n, sys_pin} = 3'h7;
      {ext1, ext2} = 2'h3;
      avs_address = 8'h00;
      avs_writedata = 32'h00000000;
      ireq = 23'h000000;
      pulses = 0;
      idle(5);
      sys_rst <= 1'b0;
      idle(1);
      `CHK("nrq idle", 1'b1, nrq_n)
      chk_rd(EVT1_IDX, 32'h00000000, "evt1 rst");
      chk_rd(EVT2_IDX, 32'h00000000, "evt2 rst");
      chk_rd(8'h3f, 32'h00000000, "unmapped");
      fire <= 1'b1;
      idle(1);
      fire <= 1'b0;
      idle(4);
      chk_rd(EVT1_IDX, 32'h00000002, "masked evt");
      `CHK("nrq masked", 1'b1, nrq_n)
      wr(NEN1_IDX, 32'h00000002);
      idle(2);
      `CHK("nrq pend", 1'b0, nrq_n)
      `CHK("frq other", 1'b1, frq_n)
      wr(FEN1_IDX, 32'h00000002);
      idle(2);
      `CHK("frq on", 1'b0, frq_n)
      service <= 1'b1;
      idle(1);
      service <= 1'b0;
      idle(4);
      chk_rd(EVT1_IDX, 32'h00000000, "withdrawn");
      `CHK("nrq off", 1'b1, nrq_n)
      modem_n <= 1'b0;
      idle(5);
      chk_rd(EVT1_IDX, 32'h00000001, "modem low");
      modem_n <= 1'b1;
      ireq <= INT_SRC_MASK;
      idle(5);
      chk_rd(EVT1_IDX, {16'h0000, INT_SRC_MASK[15:0]}, "int lo");
      chk_rd(EVT2_IDX, {25'h0, INT_SRC_MASK[22:16]}, "int hi");
      ireq <= 23'h000000;
      idle(5);
      wr(EVT2_IDX, 32'h00000002);
      idle(2);
      chk_rd(EVT2_IDX, 32'h00000002, "sw set");
      wr(NEN2_IDX, 32'h00000003);
      idle(2);
      `CHK("nrq sw", 1'b0, nrq_n)
      wr(EVT2_IDX, 32'h00000000);
      idle(2);
      chk_rd(EVT2_IDX, 32'h00000000, "sw clr");
      pd <= 1'b1;
      idle(6);
      chk_rd(EVT2_IDX, 32'h00000001, "pwr down");
      `CHK("nrq sys", 1'b0, nrq_n)
      wr(NEN2_IDX, 32'h00000000);
      idle(2);
      `CHK("sys masked", 1'b1, nrq_n)
      pd <= 1'b0;
      wr(PCFG_IDX, 32'h00000040);
      idle(6);
      chk_rd(EVT2_IDX, 32'h00000001, "sys pin hi");
      sys_pin <= 1'b1;
      wr(PCFG_IDX, 32'h00000003);
      prt_n <= 1'b0;
      idle(6);
      prt_n <= 1'b1;
      idle(2);
      prt_n <= 1'b0;
      idle(6);
      chk_rd(EVT1_IDX, 32'h00000004, "edge held");
      wr(ECLR_IDX, 32'h00000001);
      idle(2);
      chk_rd(EVT1_IDX, 32'h00000000, "edge clr");
      wr(LOCK_IDX, 32'h00000000);
      idle(3);
      `CHK("lockout", 1, pulses)
      ext1 <= 1'b0;
      ext2 <= 1'b0;
      idle(5);
      chk_rd(EVT1_IDX, 32'h00002800, "ext pins");
      `CHK("nrq gpio", 1'b1, nrq_n)
      wrap_up();
   end
endmodule
`default_nettype wire
